// ### dual_gpio_port.sv
/*
  Two 8-bit GPIO ports with latches, direction, pull-up gating, real-time
  output takeover of port A and PWM / serial alternate pins on port B.
  Assumes an APB master on pclk domain clk, pins synchronous to clk, and
  PWM / serial peripherals outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dual_gpio_params.svh"

module dual_gpio_port #(
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port A pins
  input wire logic [WIDTH-1:0] portAIn,
  output logic [WIDTH-1:0] portAOut,
  output logic [WIDTH-1:0] portAOe,
  output logic [WIDTH-1:0] portAPullup,
  // Port B pins
  input wire logic [WIDTH-1:0] portBIn,
  output logic [WIDTH-1:0] portBOut,
  output logic [WIDTH-1:0] portBOe,
  output logic [WIDTH-1:0] portBPullup,
  // Alternate peripherals
  input wire logic pwmOutA,
  input wire logic pwmOutB,
  input wire logic syncSerialClockOut,
  input wire logic syncSerialClockOe,
  input wire logic syncSerialOut,
  output logic syncSerialClockIn,
  output logic syncSerialIn
);

  // Registers
  logic [WIDTH-1:0] latchA_q;
  logic [WIDTH-1:0] latchB_q;
  logic [WIDTH-1:0] dirA_q;
  logic [WIDTH-1:0] dirB_q;
  logic [7:0] pullup_q;
  logic [7:0] pwm_q;
  logic [7:0] func_q;
  logic [7:0] rt_q;
  dual_gpio_pkg::apb_state_t state_q;

  // APB access phase decode; one wait cycle then pready
  wire setupDone = psel && penable && (state_q == dual_gpio_pkg::APB_IDLE);
  // Writes land on the completing edge, with pready high, so a write and
  // the end of its transfer never fall in different cycles
  wire accessEnd = psel && penable && (state_q == dual_gpio_pkg::APB_DONE);
  wire wrEn = accessEnd && pwrite;
  wire selAData = (paddr == `ADDR_PORT_A_DATA);
  wire selADir = (paddr == `ADDR_PORT_A_DIR);
  wire selBData = (paddr == `ADDR_PORT_B_DATA);
  wire selBDir = (paddr == `ADDR_PORT_B_DIR);
  wire selPu = (paddr == `ADDR_PULLUP_OPTION);
  wire selPwm = (paddr == `ADDR_PWM_CONTROL);
  wire selFunc = (paddr == `ADDR_PORT_B_FUNC);
  wire selRt = (paddr == `ADDR_RT_CONTROL);
  wire mapped = selAData | selADir | selBData | selBDir | selPu | selPwm | selFunc | selRt;

  // Real-time nibble takeover of port A
  wire rtLow = rt_q[`RT_LOW_BIT];
  wire rtHigh = rt_q[`RT_HIGH_BIT];
  wire rtAny = rtLow | rtHigh; // Any nibble in real time locks whole latch
  wire [WIDTH-1:0] rtMask = {{(WIDTH-4){rtHigh}}, {4{rtLow}}};

  // Per-register write strobes
  wire wrAData = wrEn && selAData && !rtAny;
  wire wrADir = wrEn && selADir;
  wire wrBData = wrEn && selBData;
  wire wrBDir = wrEn && selBDir;
  wire wrPu = wrEn && selPu;
  wire wrPwm = wrEn && selPwm;
  wire wrFunc = wrEn && selFunc;
  wire wrRt = wrEn && selRt;

  // Port A drive: output mode or real-time nibble
  wire [WIDTH-1:0] oeA = ~dirA_q | rtMask;
  wire [WIDTH-1:0] pullA = dirA_q & {WIDTH{pullup_q[`PU_PORT_A_BIT]}};

  // Port B alternate function select per pin
  wire pwm_out_a = pwm_q[`PWM_CHAN0_BIT];
  wire pwm_out_b = pwm_q[`PWM_CHAN1_BIT];
  wire fsClk = func_q[`FS_CLK_BIT];
  wire fsRx = func_q[`FS_RX_BIT];
  wire fsTx = func_q[`FS_TX_BIT];

  // Port B pin values and enables; pins 5-7 stay plain port pins
  logic [WIDTH-1:0] outB;
  logic [WIDTH-1:0] oeB;
  always_comb
  begin
    outB = latchB_q;
    oeB = ~dirB_q;
    if (pwm_out_a)
    begin
      outB[0] = pwmOutA;
      oeB[0] = 1'b1;
    end
    if (pwm_out_b)
    begin
      outB[1] = pwmOutB;
      oeB[1] = 1'b1;
    end
    if (fsClk)
    begin
      outB[2] = syncSerialClockOut;
      oeB[2] = syncSerialClockOe;
    end
    if (fsRx)
    begin
      oeB[3] = 1'b0;
    end
    if (fsTx)
    begin
      outB[4] = syncSerialOut;
      oeB[4] = 1'b1;
    end
  end

  // Pull-ups follow direction even on alternate output pins
  wire [WIDTH-1:0] pullB = dirB_q & {WIDTH{pullup_q[`PU_PORT_B_BIT]}};

  // Port reads: pin for inputs, latch for outputs
  // Real-time nibbles count as driven, so their latch stays readable
  wire [WIDTH-1:0] readA = (oeA & latchA_q) | (~oeA & portAIn);
  // Alternate pins read live pin level so it is always visible
  wire [WIDTH-1:0] altB = {{(WIDTH-5){1'b0}}, fsTx, fsRx, fsClk, pwm_out_b, pwm_out_a};
  wire [WIDTH-1:0] pinRdB = dirB_q | altB;
  wire [WIDTH-1:0] readB = (~pinRdB & latchB_q) | (pinRdB & portBIn);

  // Read mux, zero above the 8-bit registers
  logic [7:0] rdByte;
  always_comb
  begin
    rdByte = 8'h00;
    if (selAData)
      rdByte = readA;
    if (selADir)
      rdByte = dirA_q;
    if (selBData)
      rdByte = readB;
    if (selBDir)
      rdByte = dirB_q;
    if (selPu)
      rdByte = pullup_q;
    if (selPwm)
      rdByte = pwm_q;
    if (selFunc)
      rdByte = func_q;
    if (selRt)
      rdByte = rt_q;
  end

  // APB handshake: answer one cycle after the access phase begins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= dual_gpio_pkg::APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      case (state_q)
        dual_gpio_pkg::APB_IDLE:
        begin
          pready <= setupDone;
          pslverr <= setupDone && !mapped;
          if (setupDone)
          begin
            prdata <= {24'h00_0000, rdByte};
            state_q <= dual_gpio_pkg::APB_DONE;
          end
        end
        dual_gpio_pkg::APB_DONE:
        begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          state_q <= dual_gpio_pkg::APB_IDLE;
        end
        default:
        begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          state_q <= dual_gpio_pkg::APB_IDLE;
        end
      endcase
    end
  end

  // Port A latch: a whole-byte write hits every bit and holds until the
  // next one. Bit operations arrive as full-byte writes, so input latches
  // take the pin level read back; software must expect that.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latchA_q <= `RST_LATCH;
    end
    else if (clkEn && wrAData)
    begin
      latchA_q <= pwdata[WIDTH-1:0];
    end
  end

  // Port B latch: same rules, never locked
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latchB_q <= `RST_LATCH;
    end
    else if (clkEn && wrBData)
    begin
      latchB_q <= pwdata[WIDTH-1:0];
    end
  end

  // Direction registers; all ones keeps every pin an input after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dirA_q <= `RST_DIR;
      dirB_q <= `RST_DIR;
    end
    else if (clkEn)
    begin
      if (wrADir)
        dirA_q <= pwdata[WIDTH-1:0];
      if (wrBDir)
        dirB_q <= pwdata[WIDTH-1:0];
    end
  end

  // Option registers; unused bits are stored so software reads them back
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pullup_q <= `RST_PULLUP;
      pwm_q <= `RST_CTRL;
      func_q <= `RST_CTRL;
      rt_q <= `RST_CTRL;
    end
    else if (clkEn)
    begin
      if (wrPu)
        pullup_q <= pwdata[7:0];
      if (wrPwm)
        pwm_q <= pwdata[7:0];
      if (wrFunc)
        func_q <= pwdata[7:0];
      if (wrRt)
        rt_q <= pwdata[7:0];
    end
  end

  // Port A pin drive, registered; follows control one cycle after a write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      portAOut <= {WIDTH{1'b0}};
      portAOe <= {WIDTH{1'b0}};
      portAPullup <= {WIDTH{1'b0}};
    end
    else if (clkEn)
    begin
      portAOut <= latchA_q;
      portAOe <= oeA;
      portAPullup <= pullA;
    end
  end

  // Port B pin drive, registered like port A
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      portBOut <= {WIDTH{1'b0}};
      portBOe <= {WIDTH{1'b0}};
      portBPullup <= {WIDTH{1'b0}};
    end
    else if (clkEn)
    begin
      portBOut <= outB;
      portBOe <= oeB;
      portBPullup <= pullB;
    end
  end

  // Serial inputs read 0 while their pin is not selected, so the
  // peripheral never sees ordinary port traffic
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncSerialClockIn <= 1'b0;
      syncSerialIn <= 1'b0;
    end
    else if (clkEn)
    begin
      syncSerialClockIn <= portBIn[2] & fsClk;
      syncSerialIn <= portBIn[3] & fsRx;
    end
  end

endmodule : dual_gpio_port
`default_nettype wire

// ### dual_gpio_params.svh
/*
  Register offsets, field positions and reset values for the dual GPIO port.
  Assumes inclusion by bare name from the design file.
*/
`ifndef DUAL_GPIO_PARAMS_SVH
`define DUAL_GPIO_PARAMS_SVH

// Register byte addresses (APB, one word each)
`define ADDR_PORT_A_DATA 18'h0_0000
`define ADDR_PORT_A_DIR 18'h0_0004
`define ADDR_PORT_B_DATA 18'h0_0008
`define ADDR_PORT_B_DIR {`IDX_PORT_B_DIR, 2'b00}
`define ADDR_PULLUP_OPTION {`IDX_PULLUP_OPTION, 2'b00}
`define ADDR_PWM_CONTROL 18'h0_0010
`define ADDR_PORT_B_FUNC 18'h0_0014
`define ADDR_RT_CONTROL 18'h0_0018

// Register indices; word indices, so the byte address is four times the index
`define IDX_PORT_B_DIR 16'hff21
`define IDX_PULLUP_OPTION 16'hff4e

// Reset values
`define RST_DIR 8'hff
`define RST_PULLUP 8'h00
`define RST_LATCH 8'h00
`define RST_CTRL 8'h00

// Field positions
`define PU_PORT_A_BIT 0
`define PU_PORT_B_BIT 1
`define PWM_CHAN0_BIT 0
`define PWM_CHAN1_BIT 1
`define RT_LOW_BIT 0
`define RT_HIGH_BIT 1
`define FS_CLK_BIT 2
`define FS_RX_BIT 3
`define FS_TX_BIT 4

`endif

// ### dual_gpio_pkg.sv
/*
  Types for the dual GPIO port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dual_gpio_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_DONE = 2'b01
  } apb_state_t;
endpackage : dual_gpio_pkg

// ### dual_gpio_props.sv
/* Port-level checker for the dual GPIO port.
   Assumes it is bound onto dual_gpio_port with one clock. */
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [7:0] portBIn,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] portBOe,
  input wire logic [7:0] portAPullup,
  input wire logic [7:0] portBPullup,
  input wire logic syncSerialIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bus phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_ready_after: assert property (s_setup ##1 s_access |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_idle: assert property (!(psel && penable) |=> !pready)
    else $error("ready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == '0)
    else $error("upper read bits set");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> (portAOe | portBOe) == '0
    && (portAPullup | portBPullup) == '0) else $error("pins active in reset");
  a_pull_input: assert property ((portBPullup[7:5] & portBOe[7:5]) == '0)
    else $error("pull-up on driven pin");
  a_rx_gated: assert property (syncSerialIn |-> $past(portBIn[3]))
    else $error("serial input not from pin");
  a_rx_input: assert property (syncSerialIn |-> !portBOe[3])
    else $error("serial input pin driven");
endmodule : dual_gpio_props
bind dual_gpio_port dual_gpio_props dual_gpio_props_inst (.clk, .rst, .psel, .penable,
  .prdata, .pready, .pslverr, .portBIn, .portAOe, .portBOe, .portAPullup, .portBPullup,
  .syncSerialIn);
`default_nettype wire

// ### gpio_pins_model.sv
/* Board model of the two ports' pins.
   Assumes device drive, far-side drive and pull-ups meet here. */
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [7:0] aOut,
  input wire logic [7:0] aOe,
  input wire logic [7:0] aPull,
  input wire logic [7:0] bOut,
  input wire logic [7:0] bOe,
  input wire logic [7:0] bPull,
  // Far side drive
  input wire logic [7:0] extA,
  input wire logic [7:0] extB,
  input wire logic [7:0] extAEn,
  input wire logic [7:0] extBEn,
  // Wire levels
  output logic [7:0] pinA,
  output logic [7:0] pinB
);
  logic [7:0] drift_q = 8'h55;
  // Floating pins wander so a stale level never passes
  always_ff @(posedge clk) drift_q <= ~drift_q;
  // Device wins, then far side, then pull-up
  assign pinA = aOe & aOut | ~aOe & (extAEn & extA | ~extAEn & (aPull | drift_q));
  assign pinB = bOe & bOut | ~bOe & (extBEn & extB | ~extBEn & (bPull | drift_q));
endmodule : gpio_pins_model
`default_nettype wire

// ### dual_gpio_port_with_pullups_tb.sv
/* Register-level bench for the dual GPIO port.
   Assumes the pin model stands on both ports. */
`timescale 1ns/1ps
`default_nettype none
`include "dual_gpio_params.svh"
module dual_gpio_port_with_pullups_tb;
  logic clk = 0, rst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic pwmA = 0, pwmB = 0, sOut = 0, sClkOut = 0, sClkOe = 0, clkEn = 1, sClkIn, sIn;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] aOut, aOe, aPull, bOut, bOe, bPull, pinA, pinB;
  logic [7:0] extA = 8'h3c, extB = 8'hff, extAEn = 8'hff, extBEn = 8'hff;
  int badCount = 0, checkCount = 0;
  dual_gpio_port dual_gpio_port_inst (.clk, .rst, .clkEn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .portAIn(pinA), .portAOut(aOut),
    .portAOe(aOe), .portAPullup(aPull), .portBIn(pinB), .portBOut(bOut), .portBOe(bOe),
    .portBPullup(bPull), .pwmOutA(pwmA), .pwmOutB(pwmB), .syncSerialClockOut(sClkOut),
    .syncSerialClockOe(sClkOe), .syncSerialOut(sOut), .syncSerialClockIn(sClkIn),
    .syncSerialIn(sIn));
  gpio_pins_model gpio_pins_model_inst (.clk, .aOut, .aOe, .aPull, .bOut, .bOe, .bPull,
    .extA, .extB, .extAEn, .extBEn, .pinA, .pinB);
  // Clock
  initial forever #20 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask : rd
  task endOfTest;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : endOfTest
  // Tests
  initial
  begin
    // Raised at time zero by a nonblocking assignment so the asynchronous reset sees an edge
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ADDR_PORT_B_DIR, 32'h0000_00ff, 1'b0);
    rd(`ADDR_PORT_A_DIR, 32'h0000_00ff, 1'b0);
    rd(`ADDR_PULLUP_OPTION, 32'h0000_0000, 1'b0);
    chk(32'({aOe, bOe}), 32'h0000_0000);
    $display("reset test done");
    wr(`ADDR_PORT_A_DATA, 8'h5a);
    rd(`ADDR_PORT_A_DATA, 32'h0000_003c, 1'b0);
    wr(`ADDR_PORT_A_DIR, 8'h0f);
    rd(`ADDR_PORT_A_DATA, 32'h0000_005c, 1'b0);
    chk(32'({aOe, aOut & aOe}), 32'h0000_f050);
    wr(`ADDR_PULLUP_OPTION, 8'h03);
    rd(`ADDR_PULLUP_OPTION, 32'h0000_0003, 1'b0);
    chk(32'({aPull, bPull}), 32'h0000_0fff);
    wr(`ADDR_RT_CONTROL, 8'h01);
    wr(`ADDR_PORT_A_DATA, 8'ha5);
    chk(32'({aOe, aOut}), 32'h0000_ff5a);
    wr(`ADDR_RT_CONTROL, 8'h00);
    wr(`ADDR_PORT_A_DIR, 8'h00);
    rd(`ADDR_PORT_A_DATA, 32'h0000_005a, 1'b0);
    // Bit set by whole-port read-modify-write overwrites input latches
    wr(`ADDR_PORT_A_DIR, 8'hf0);
    rd(`ADDR_PORT_A_DATA, 32'h0000_003a, 1'b0);
    wr(`ADDR_PORT_A_DATA, 8'h3b);
    wr(`ADDR_PORT_A_DIR, 8'h00);
    rd(`ADDR_PORT_A_DATA, 32'h0000_003b, 1'b0);
    $display("port A test done");
    wr(`ADDR_PORT_B_DATA, 8'he0);
    wr(`ADDR_PORT_B_DIR, 8'h00);
    wr(`ADDR_PWM_CONTROL, 8'h03);
    wr(`ADDR_PORT_B_FUNC, 8'h1c);
    // Peripheral levels differ from the latch so a missing takeover shows
    pwmA <= 1'b1;
    pwmB <= 1'b1;
    sOut <= 1'b1;
    sClkOut <= 1'b1;
    sClkOe <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'({bOut[7:4], bOut[1:0], sIn, sClkIn, bOe[3:2]}), 32'h0000_03fd);
    rd(`ADDR_PORT_B_DATA, 32'h0000_00ff, 1'b0);
    // Clock enable low freezes the pin registers
    clkEn <= 1'b0;
    pwmA <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(bOut[0]), 32'h0000_0001);
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(bOut[0]), 32'h0000_0000);
    rd(18'h0_0020, 32'h0000_0000, 1'b1);
    $display("port B test done");
    endOfTest();
  end
  // Watchdog
  initial
  begin
    #20000;
    badCount++;
    endOfTest();
  end
endmodule : dual_gpio_port_with_pullups_tb
`default_nettype wire
